// >>> rtl/bmde_top.sv
// boot rom, program flash, data flash with ecc, data ram and the address decoder
//
// What this block does
// RULE1 - boot rom holds 1024 words of 32 bits of startup firmware
// RULE2 - after reset the decoder presents the rom map so execution starts in rom
// RULE3 - switch to flash execution only taken when program flash holds a valid image
// RULE4 - program flash holds 8k words of 32 bits as program space
// RULE5 - program flash erases one 1 kbyte page or the whole array
// RULE6 - data flash holds 512 words of 32 user bits
// RULE7 - data ram holds 1024 words, read and written at run time
// RULE8 - each data flash write stores six check bits computed from the data
// RULE9 - data flash reads correct any single-bit error before returning data
// RULE10 - decoder serves one of two maps, rom or flash, chosen by boot code
// RULE11 - rom map: boot rom at zero, mirrored over sixteen 4 kbyte blocks, select 0
// RULE12 - rom map: flash select 1, gap unused, data flash select 2, ram select 3
// RULE13 - flash map: program flash at zero, boot rom moved to 0xa000 block
// RULE14 - unused ranges assert no select and change no memory
`timescale 1ns/1ps
module bmde_top import bmde_pkg::*; #(
  parameter logic [31:0] ROM_IMAGE [ROM_WORDS] = '{default: 32'h0}
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire bmde_req_t cpu_req_i,
  output bmde_rsp_t cpu_rsp_o,
  input wire logic map_switch_i,
  input wire bmde_erase_t erase_i,
  output logic flash_map_o,
  output logic prog_valid_o
);
  // arrays; flash and ram contents are not reset
  logic [31:0] rom_mem [ROM_WORDS]; // [RULE1]
  logic [31:0] prog_mem [PROG_WORDS]; // [RULE4]
  logic [CODE_BITS-1:0] dfl_mem [DFL_WORDS]; // [RULE6]
  logic [31:0] ram_mem [RAM_WORDS]; // [RULE7]

  bmde_map_t map, next_map;
  bmde_rsp_t rsp, next_rsp;
  logic [3:0] sel;
  logic [12:0] idx;
  logic prog_valid;
  logic [CODE_BITS-1:0] dfl_code;

  assign rom_mem = ROM_IMAGE;

  // spread data over hamming positions 1..38, leaving power-of-two slots empty
  function automatic logic [CODE_BITS:0] ecc_spread(input logic [31:0] d);
    logic [CODE_BITS:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= CODE_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    return c;
  endfunction : ecc_spread

  // parity over every position whose index has bit k set
  function automatic logic [ECC_BITS-1:0] ecc_syndrome(input logic [CODE_BITS:0] c);
    logic [ECC_BITS-1:0] s;
    s = '0;
    for (int p = 1; p <= CODE_BITS; p++) begin
      for (int k = 0; k < ECC_BITS; k++) begin
        if (p[k]) s[k] = s[k] ^ c[p];
      end
    end
    return s;
  endfunction : ecc_syndrome

  // build the stored codeword: check bits fill the power-of-two slots
  function automatic logic [CODE_BITS-1:0] ecc_encode(input logic [31:0] d);
    logic [CODE_BITS:0] c;
    logic [ECC_BITS-1:0] s;
    c = ecc_spread(d);
    s = ecc_syndrome(c);
    for (int k = 0; k < ECC_BITS; k++) begin
      c[1 << k] = s[k];
    end
    return c[CODE_BITS:1];
  endfunction : ecc_encode

  // flip the bit named by the syndrome, then gather the data bits back
  function automatic logic [32:0] ecc_decode(input logic [CODE_BITS-1:0] code);
    logic [CODE_BITS:0] c;
    logic [ECC_BITS-1:0] s;
    logic [31:0] d;
    int j;
    c = {code, 1'b0};
    s = ecc_syndrome(c);
    d = '0;
    j = 0;
    if (s != '0 && int'(s) <= CODE_BITS) c[s] = ~c[s];
    for (int p = 1; p <= CODE_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p];
        j++;
      end
    end
    return {s != '0, d};
  endfunction : ecc_decode

  // every single-bit flip of a clean codeword must decode back to its data
  function automatic logic ecc_fix_ok(input logic [CODE_BITS-1:0] code);
    logic [32:0] clean;
    logic [32:0] hit;
    logic ok;
    clean = ecc_decode(code);
    ok = !clean[32];
    for (int p = 0; p < CODE_BITS; p++) begin
      hit = ecc_decode(code ^ (CODE_BITS'(1) << p));
      if (hit[31:0] != clean[31:0] || !hit[32]) ok = 1'b0;
    end
    return ok;
  endfunction : ecc_fix_ok

  // range test used by the decoder
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // address decoder: one-hot select and word index for the current map
  always_comb begin
    sel = 4'h0;
    idx = 13'h0000;
    unique case (map)
      MAP_ROM: begin
        if (in_range(cpu_req_i.addr, RM_ROM_LO, RM_ROM_HI)) begin
          sel[SEL_ROM] = 1'b1; // mirrored every 4 kbyte [RULE11]
          idx = {3'h0, cpu_req_i.addr[11:2]};
        end else if (in_range(cpu_req_i.addr, RM_PROG_LO, RM_PROG_HI)) begin
          sel[SEL_PROG] = 1'b1; // [RULE12]
          idx = cpu_req_i.addr[14:2];
        end
      end
      MAP_FLASH: begin
        if (in_range(cpu_req_i.addr, FM_PROG_LO, FM_PROG_HI)) begin
          sel[SEL_PROG] = 1'b1; // [RULE13]
          idx = cpu_req_i.addr[14:2];
        end else if (in_range(cpu_req_i.addr, FM_ROM_LO, FM_ROM_HI)) begin
          sel[SEL_ROM] = 1'b1; // [RULE13]
          idx = {3'h0, cpu_req_i.addr[11:2]};
        end
      end
    endcase
    // data flash and ram sit at the same place in both maps
    if (in_range(cpu_req_i.addr, DFL_LO, DFL_HI)) begin
      sel[SEL_DFL] = 1'b1; // [RULE12]
      idx = {4'h0, cpu_req_i.addr[10:2]};
    end else if (in_range(cpu_req_i.addr, RAM_LO, RAM_HI)) begin
      sel[SEL_RAM] = 1'b1; // [RULE12]
      idx = {3'h0, cpu_req_i.addr[11:2]};
    end
    // the 0x18000 gap and every other address fall through with no select [RULE14]
    if (!cpu_req_i.req) sel = 4'h0;
  end

  // a program image is present when the reset-vector word is not erased
  assign prog_valid = (prog_mem[0] != ERASED_WORD); // [RULE3]
  assign dfl_code = dfl_mem[idx[8:0]];

  // map choice: rom after reset, flash only on an accepted switch
  always_comb begin
    next_map = map;
    unique case (map)
      MAP_ROM: if (map_switch_i && prog_valid) next_map = MAP_FLASH; // [RULE3] [RULE10]
      MAP_FLASH: next_map = MAP_FLASH;
    endcase
  end

  // read answer, registered one cycle after the request
  always_comb begin
    logic [32:0] fixed;
    fixed = ecc_decode(dfl_code); // [RULE9]
    next_rsp = '0;
    next_rsp.valid = cpu_req_i.req;
    next_rsp.sel = sel;
    if (cpu_req_i.req && !cpu_req_i.we) begin
      unique case (1'b1)
        sel[SEL_ROM]: next_rsp.rdata = rom_mem[idx[9:0]];
        sel[SEL_PROG]: next_rsp.rdata = prog_mem[idx];
        sel[SEL_DFL]: begin
          next_rsp.rdata = fixed[31:0];
          next_rsp.corrected = fixed[32];
        end
        sel[SEL_RAM]: next_rsp.rdata = ram_mem[idx[9:0]];
        default: next_rsp.rdata = 32'h0;
      endcase
    end
  end

  // control state registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      map <= MAP_ROM; // [RULE2]
      rsp <= '0;
    end else begin
      map <= next_map;
      rsp <= next_rsp;
    end
  end

  // array writes; rom takes none, unused space reaches nothing
  always_ff @(posedge clk_i) begin
    if (cpu_req_i.req && cpu_req_i.we) begin
      if (sel[SEL_PROG]) prog_mem[idx] <= cpu_req_i.wdata;
      if (sel[SEL_DFL]) dfl_mem[idx[8:0]] <= ecc_encode(cpu_req_i.wdata); // [RULE8]
      if (sel[SEL_RAM]) ram_mem[idx[9:0]] <= cpu_req_i.wdata; // [RULE7]
    end
    // erase sets words to all ones; mass erase beats a page erase
    if (erase_i.mass_req) begin
      for (int w = 0; w < PROG_WORDS; w++) prog_mem[w] <= ERASED_WORD; // [RULE5]
    end else if (erase_i.page_req) begin
      for (int w = 0; w < PAGE_WORDS; w++) begin
        prog_mem[{erase_i.page, 8'(w)}] <= ERASED_WORD; // [RULE5]
      end
    end
  end

  assign cpu_rsp_o = rsp;
  assign flash_map_o = (map == MAP_FLASH);
  assign prog_valid_o = prog_valid;

  // checks
  a_rsp_timing: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7]
    cpu_req_i.req |=> rsp.valid) else $error("request without answer");
  a_switch_gated: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE3]
    (map == MAP_FLASH) && ($past(map) == MAP_ROM) |-> $past(map_switch_i && prog_valid))
    else $error("flash map without valid image");
  a_map_sticky: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE10]
    map == MAP_FLASH |=> map == MAP_FLASH) else $error("map left flash mode");
  a_rom_mirror: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE11]
    cpu_req_i.req && !cpu_req_i.we && map == MAP_ROM && cpu_req_i.addr <= RM_ROM_HI
    |=> rsp.sel == 4'h1 && rsp.rdata == rom_mem[$past(cpu_req_i.addr[11:2])])
    else $error("rom mirror read wrong");
  a_unused_nosel: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE14]
    cpu_req_i.req && in_range(cpu_req_i.addr, UNUSED_LO, UNUSED_HI)
    |=> rsp.sel == 4'h0 && rsp.rdata == 32'h0) else $error("unused range selected");
  a_flash_prog: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE13]
    cpu_req_i.req && map == MAP_FLASH && cpu_req_i.addr <= FM_PROG_HI
    |=> rsp.sel == 4'h2) else $error("flash map program decode wrong");
  a_ram_readback: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE7]
    (cpu_req_i.req && cpu_req_i.we && sel[SEL_RAM]) ##1
    (cpu_req_i.req && !cpu_req_i.we && cpu_req_i.addr == $past(cpu_req_i.addr))
    |=> rsp.rdata == $past(cpu_req_i.wdata, 2)) else $error("ram readback wrong");
  a_ecc_clean: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE8] [RULE9]
    (cpu_req_i.req && cpu_req_i.we && sel[SEL_DFL]) ##1
    (cpu_req_i.req && !cpu_req_i.we && cpu_req_i.addr == $past(cpu_req_i.addr))
    |=> rsp.rdata == $past(cpu_req_i.wdata, 2) && !rsp.corrected)
    else $error("data flash readback wrong");
  a_ecc_single: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE9]
    cpu_req_i.req && cpu_req_i.we && sel[SEL_DFL]
    |-> ecc_fix_ok(ecc_encode(cpu_req_i.wdata)))
    else $error("single-bit error not corrected");
  a_mass_erase: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE5]
    erase_i.mass_req |=> !prog_valid) else $error("mass erase left image");
endmodule : bmde_top

// >>> rtl/bmde_pkg.sv
// constants and types shared by the boot memory decode block
package bmde_pkg;
  // word counts of each array
  localparam int ROM_WORDS = 1024;
  localparam int PROG_WORDS = 8192;
  localparam int DFL_WORDS = 512;
  localparam int RAM_WORDS = 1024;
  localparam int PAGE_WORDS = 256; // 1 kbyte erase page
  localparam int PAGES = PROG_WORDS / PAGE_WORDS;
  localparam int ECC_BITS = 6;
  localparam int CODE_BITS = 32 + ECC_BITS;

  // memory select one-hot positions
  localparam int SEL_ROM = 0;
  localparam int SEL_PROG = 1;
  localparam int SEL_DFL = 2;
  localparam int SEL_RAM = 3;

  // rom-execution map
  localparam logic [31:0] RM_ROM_LO = 32'h0000_0000;
  localparam logic [31:0] RM_ROM_HI = 32'h0000_ffff; // 16 mirrored 4 kbyte blocks
  localparam logic [31:0] RM_PROG_LO = 32'h0001_0000;
  localparam logic [31:0] RM_PROG_HI = 32'h0001_7fff;
  // flash-execution map
  localparam logic [31:0] FM_PROG_LO = 32'h0000_0000;
  localparam logic [31:0] FM_PROG_HI = 32'h0000_7fff;
  localparam logic [31:0] FM_ROM_LO = 32'h0000_a000;
  localparam logic [31:0] FM_ROM_HI = 32'h0000_afff;
  // common to both maps
  localparam logic [31:0] UNUSED_LO = 32'h0001_8000;
  localparam logic [31:0] UNUSED_HI = 32'h0001_87ff;
  localparam logic [31:0] DFL_LO = 32'h0001_8800;
  localparam logic [31:0] DFL_HI = 32'h0001_8fff;
  localparam logic [31:0] RAM_LO = 32'h0001_9000;
  localparam logic [31:0] RAM_HI = 32'h0001_9fff;

  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

  typedef enum logic {MAP_ROM, MAP_FLASH} bmde_map_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmde_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] sel;
    logic corrected;
    logic [31:0] rdata;
  } bmde_rsp_t;

  typedef struct packed {
    logic page_req;
    logic mass_req;
    logic [4:0] page;
  } bmde_erase_t;
endpackage : bmde_pkg

// >>> sim/bmde_cpu_model.sv
// processor-side model issuing single word transfers
`timescale 1ns/1ps
module bmde_cpu_model import bmde_pkg::*; (
  input wire logic clk_i,
  output bmde_req_t req_o,
  input wire bmde_rsp_t rsp_i
);
  // idle bus before the first transfer
  initial req_o = '0;

  // drive on falling edge, hold past the taking edge, sample answer a cycle later
  task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d,
                      output bmde_rsp_t r);
    @(negedge clk_i);
    req_o <= '{1'b1, we, a, d};
    @(negedge clk_i);
    r = rsp_i;
    req_o <= '{1'b0, ~we, ~a, ~d}; // released lines flip, never hold stale values
  endtask : xfer

  // write then read of the same word on back-to-back cycles
  task automatic xfer2(input logic [31:0] a, input logic [31:0] d,
                       output bmde_rsp_t r1, output bmde_rsp_t r2);
    @(negedge clk_i);
    req_o <= '{1'b1, 1'b1, a, d};
    @(negedge clk_i);
    r1 = rsp_i;
    req_o <= '{1'b1, 1'b0, a, ~d}; // read straight after the write
    @(negedge clk_i);
    r2 = rsp_i;
    req_o <= '{1'b0, 1'b1, ~a, d};
  endtask : xfer2
endmodule : bmde_cpu_model

// >>> sim/boot_memory_decode_ecc_tb.sv
// self-checking bench for the boot memory decode block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module boot_memory_decode_ecc_tb;
  import bmde_pkg::*;
  typedef logic [31:0] img_t [ROM_WORDS];
  // rom words carry their own index so mirroring errors show
  function automatic img_t mk_img();
    for (int i = 0; i < ROM_WORDS; i++) mk_img[i] = {16'(i) ^ 16'h3c5a, 16'(i)};
  endfunction : mk_img
  localparam img_t IMG = mk_img();

  logic clk, reset, map_sw, fmap, pval, fm;
  bmde_req_t req;
  bmde_rsp_t rsp;
  bmde_erase_t er;
  int num_errors, total_checks, seed;
  logic [31:0] pm [int];
  logic [31:0] dm [int];
  logic [31:0] rm [int];
  logic [31:0] bases [10] = '{32'h0, 32'h7000, 32'hf000, 32'h1_0000, 32'h1_7fc0,
                              32'h1_8000, 32'h1_8800, 32'h1_9000, 32'ha000, 32'hb000};

  always #12.5 clk = ~clk;

  bmde_top #(.ROM_IMAGE(IMG)) dut (.clk_i(clk), .reset_i(reset), .cpu_req_i(req),
    .cpu_rsp_o(rsp), .map_switch_i(map_sw), .erase_i(er), .flash_map_o(fmap),
    .prog_valid_o(pval));
  bmde_cpu_model cpu (.clk_i(clk), .req_o(req), .rsp_i(rsp));

  // expected select for the current map
  function automatic logic [3:0] exp_sel(input logic [31:0] a);
    if (a >= 32'h1_8800 && a <= 32'h1_8fff) return 4'h4;
    if (a >= 32'h1_9000 && a <= 32'h1_9fff) return 4'h8;
    if (!fm) return (a <= 32'hffff) ? 4'h1 : (a <= 32'h1_7fff) ? 4'h2 : 4'h0;
    return (a <= 32'h7fff) ? 4'h2 : (a >= 32'ha000 && a <= 32'hafff) ? 4'h1 : 4'h0;
  endfunction : exp_sel

  // one answer compared against the reference model
  task automatic chk(input logic we, input logic [31:0] a, input logic [31:0] d,
                     input bmde_rsp_t r);
    logic [3:0] s;
    logic [31:0] e;
    logic known;
    s = exp_sel(a);
    e = 32'h0;
    known = 1'b1;
    `CHK("valid", 1'b1, r.valid)
    `CHK("sel", s, r.sel)
    if (we) begin
      if (s == 4'h2) pm[a[14:2]] = d;
      if (s == 4'h4) dm[a[10:2]] = d;
      if (s == 4'h8) rm[a[11:2]] = d;
    end else begin
      case (s)
        4'h1: e = IMG[a[11:2]];
        4'h2: e = pm.exists(a[14:2]) ? pm[a[14:2]] : 32'hffff_ffff;
        4'h4: begin
          known = dm.exists(a[10:2]);
          e = known ? dm[a[10:2]] : 32'h0;
          if (known) `CHK("corrected", 1'b0, r.corrected)
        end
        4'h8: begin
          known = rm.exists(a[11:2]);
          e = known ? rm[a[11:2]] : 32'h0;
        end
        default: e = 32'h0;
      endcase
    end
    if (known) `CHK("rdata", e, r.rdata)
  endtask : chk

  // single transfer with a bus gap after it
  task automatic op(input logic we, input logic [31:0] a, input logic [31:0] d);
    bmde_rsp_t r;
    cpu.xfer(we, a, d, r);
    chk(we, a, d, r);
  endtask : op

  // back-to-back write and read of one word
  task automatic pair(input logic [31:0] a, input logic [31:0] d);
    bmde_rsp_t r1;
    bmde_rsp_t r2;
    cpu.xfer2(a, d, r1, r2);
    chk(1'b1, a, d, r1);
    chk(1'b0, a, d, r2);
  endtask : pair

  // random mix of reads and writes over every region and every gap except the flash-map hole below 0xa000
  task automatic rand_ops(input int n);
    logic [31:0] a;
    for (int i = 0; i < n; i++) begin
      a = bases[{$random(seed)} % 10] + (({$random(seed)} % 16) << 2);
      if ({$random(seed)} % 4 == 0) pair(a, $random(seed));
      else op(1'($random(seed)), a, $random(seed));
    end
  endtask : rand_ops

  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED watchdog exp done got timeout");
    results();
  end

  initial begin
    clk = 0; reset = 1; map_sw = 0; er = '0; fm = 0;
    seed = 93424; num_errors = 0; total_checks = 0;
    repeat (12) @(negedge clk);
    reset = 0;
    `CHK("map", 1'b0, fmap)
    er <= '{1'b0, 1'b1, 5'h0};
    @(negedge clk);
    er <= '0;
    pm.delete();
    `CHK("pvalid", 1'b0, pval)
    map_sw <= 1;
    @(negedge clk);
    map_sw <= 0;
    @(negedge clk);
    `CHK("refused", 1'b0, fmap)
    rand_ops(150);
    op(1, 32'h1_0400, 32'h1234_5678);
    er <= '{1'b1, 1'b0, 5'h1};
    @(negedge clk);
    er <= '0;
    for (int i = 0; i < 256; i++) pm.delete(256 + i);
    op(0, 32'h1_0400, 32'h0);
    op(1, 32'h1_0000, 32'h0000_00a5);
    `CHK("pvalid", 1'b1, pval)
    map_sw <= 1;
    @(negedge clk);
    map_sw <= 0;
    `CHK("switch", 1'b1, fmap)
    fm = 1;
    op(0, 32'h0, 32'h0);
    rand_ops(150);
    results();
  end
endmodule : boot_memory_decode_ecc_tb
